//--- rtl/column_driver_end.sv
// Column driver digital front end: load chain, line latch, output stage
// What this block does
// - Word is six 6-bit dots, bit0 LSB
// - Direction picks input pin, order, output pin
// - Open direction input reads as right shift
// - Loading starts on start pulse high
// - Upstream start pulse lasts one clock
// - Long start pulse counts only once
// - Capture word each edge, first 80, or 70
// - Start out at edge 80, or 70
// - Loading halts after 82, or 72 clocks
// - Strobe rise clears the position chain
// - Strobe rise copies data into latches
// - Strobe fall drives latched levels out
// - One line strobe every line
// - Polarity swaps reference groups odd/even
// - Polarity sampled at strobe rising edge
// - Low invert flag complements dots 0-2
// - High invert flag complements dots 3-5
// - Channel select picks 480 or 420
// - Open channel select means 420 outputs
// - Low-power input, open means normal
`timescale 1ns/1ps
`default_nettype none
`include "column_loader_regs.svh"
module column_driver_end (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Link to the controller
  column_link_if.dev link,
  // Output stage
  output logic [`CL_COLS*`CL_DOT_W-1:0] o_column_outputs,
  output logic [`CL_COLS-1:0] o_column_used,
  output logic o_odd_upper_group,
  output logic o_low_power,
  output logic o_loading
);

  // All driver state in one record; the three rows dominate its size
  // Rows hold 480 six-bit dots: data register, line latch, levels
  typedef struct packed {
    logic loading;
    logic [6:0] cnt;
    logic start_prev;
    logic stb_prev;
    logic carry;
    logic pol_lat;
    logic odd_upper;
    logic low_power;
    logic [`CL_COLS-1:0] used;
    column_loader_pkg::row_type data_reg;
    column_loader_pkg::row_type latch;
    column_loader_pkg::row_type levels;
  } drv_state_type;

  drv_state_type st_r;
  drv_state_type st_nxt;

  // Map a load position and dot to its output column
  function automatic logic [8:0] col_index(input logic [6:0] pos,
                                           input logic [2:0] dot,
                                           input logic right,
                                           input logic full);
    logic [9:0] n;
    n = 10'(pos) * 10'd6 + 10'(dot);
    if (!full && n >= `CL_GAP_FIRST) begin
      n = n + `CL_GAP_LEN; // Middle sixty columns skipped
    end
    // Left shift mirrors the whole row, dots within a word included
    if (!right) begin
      n = `CL_LAST_COL - n; // Left shift fills from the last column
    end
    return n[8:0];
  endfunction : col_index

  // Conditional six-bit complement of one dot
  function automatic column_loader_pkg::dot_type flip(
      input column_loader_pkg::dot_type d, input logic inv);
    return inv ? ~d : d; // Code n becomes 63 - n
  endfunction : flip

  // Columns the output stage drives; 420 mode leaves the middle idle
  function automatic logic [`CL_COLS-1:0] used_mask(input logic all_cols);
    logic [`CL_COLS-1:0] m;
    m = '1;
    if (!all_cols) begin
      for (int c = 0; c < int'(`CL_GAP_LEN); c++) begin
        m[int'(`CL_GAP_FIRST) + c] = 1'b0; // Sixty unused columns
      end
    end
    return m;
  endfunction : used_mask

  logic right;
  logic full;
  logic start_in;
  logic start_rise;
  logic stb_rise;
  logic stb_fall;
  logic [6:0] n_clk;
  logic [6:0] n_halt;

  // Pull resolution of the strap inputs; an open pin reads as its pull
  // Mode pins are read live: the counts move with them, so the
  // controller must only change them between lines
  assign right = link.dir_open ? 1'b1 : link.dir_sel;
  assign full = link.chan_open ? 1'b0 : link.chan_sel;
  assign n_clk = full ? `CL_CLK_FULL : `CL_CLK_PART;
  assign n_halt = full ? `CL_HALT_FULL : `CL_HALT_PART;

  // Start input chosen by direction; only its first high clock counts
  // A pulse held for several clocks restarts nothing: start_prev masks
  // every high clock after the first
  assign start_in = right ? link.right_chain_pulse
                          : link.left_chain_pulse;
  assign start_rise = start_in && !st_r.start_prev;
  // Strobe edges are found against last clock's level
  assign stb_rise = link.line_strobe && !st_r.stb_prev;
  assign stb_fall = !link.line_strobe && st_r.stb_prev;

  // Next state of the whole driver
  always_comb begin
    logic [6:0] pos;
    logic cap;
    column_loader_pkg::dot_type d;
    pos = 7'd0;
    cap = 1'b0;
    d = '0;
    // Hold everything unless a branch below moves it
    st_nxt = st_r;
    st_nxt.start_prev = start_in;
    st_nxt.stb_prev = link.line_strobe;
    st_nxt.low_power = link.lpc_open ? 1'b0 : !link.low_power_ctl;
    st_nxt.carry = st_r.loading && (st_r.cnt == n_clk);
    // Strobe rise ends the current line and latches the row
    if (stb_rise) begin
      st_nxt.loading = 1'b0;
      st_nxt.cnt = 7'd0;
      st_nxt.latch = st_r.data_reg;
      st_nxt.pol_lat = link.output_polarity;
    end
    if (stb_fall) begin
      st_nxt.levels = st_r.latch;
      st_nxt.odd_upper = !st_r.pol_lat;
      st_nxt.used = used_mask(full);
    end
    // Start wins over a strobe rise in the same cycle, so a new line is
    // never lost to a late strobe; cnt counts edges since the start edge
    // and doubles as the load position while it is below the cascade
    // count, so no separate position chain is kept
    if (start_rise) begin
      st_nxt.loading = 1'b1;
      st_nxt.cnt = 7'd1;
      pos = 7'd0;
      cap = 1'b1;
    end else if (st_r.loading) begin
      if (!stb_rise) begin
        st_nxt.cnt = st_r.cnt + 7'd1;
      end
      // Words past the cascade count are dropped until the halt
      if (st_r.cnt == n_halt) begin
        st_nxt.loading = 1'b0; // Self halt until the next start
        st_nxt.cnt = 7'd0;
      end else if (st_r.cnt < n_clk) begin
        pos = st_r.cnt;
        cap = 1'b1;
      end
    end
    // Six dots per word, inverted per port as they are loaded
    // Inversion happens on the way in, so the latch holds final codes
    if (cap) begin
      for (int j = 0; j < `CL_DOTS; j++) begin
        d = link.pixel_word_in[j*`CL_DOT_W +: `CL_DOT_W];
        d = flip(d, (j < 3) ? link.invert_low_dots
                            : link.invert_high_dots);
        st_nxt.data_reg[col_index(pos, 3'(j), right, full)] = d;
      end
    end
  end

  // State register; no reset pin on the real part, modelled here so
  // that simulation starts from known rows and a closed loading window
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outgoing start pulse on the pin opposite the input
  // Both data pins carry the pulse; only the enable picks the pin, which
  // keeps the input pin free for the upstream party
  assign link.right_dev = st_r.carry;
  assign link.left_dev = st_r.carry;
  assign link.right_dev_oe_n = right; // Drives only in left shift
  assign link.left_dev_oe_n = !right; // Drives only in right shift

  // Output stage; levels and groups move only on a strobe fall, so the
  // panel never sees a half loaded line
  assign o_column_outputs = st_r.levels;
  assign o_column_used = st_r.used;
  assign o_odd_upper_group = st_r.odd_upper;
  assign o_low_power = st_r.low_power;
  assign o_loading = st_r.loading;

endmodule : column_driver_end
`default_nettype wire

//--- rtl/column_link_if.sv
// Link between the timing controller and the column driver
`timescale 1ns/1ps
`default_nettype none
interface column_link_if;
  logic [35:0] pixel_word_in;
  logic right_ctl, right_ctl_oe_n, right_dev, right_dev_oe_n;
  logic left_ctl, left_ctl_oe_n, left_dev, left_dev_oe_n;
  logic right_chain_pulse, left_chain_pulse;
  logic line_strobe;
  logic dir_sel, dir_open;
  logic output_polarity, invert_low_dots, invert_high_dots;
  logic chan_sel, chan_open;
  logic low_power_ctl, lpc_open;
  // Resolved chain pins; an undriven pin reads low
  assign right_chain_pulse = !right_ctl_oe_n ? right_ctl :
                             (!right_dev_oe_n ? right_dev : 1'b0);
  assign left_chain_pulse = !left_ctl_oe_n ? left_ctl :
                            (!left_dev_oe_n ? left_dev : 1'b0);
  modport dev (
    input pixel_word_in, right_chain_pulse, left_chain_pulse, line_strobe,
    input dir_sel, dir_open, output_polarity, invert_low_dots,
    input invert_high_dots, chan_sel, chan_open, low_power_ctl, lpc_open,
    output right_dev, right_dev_oe_n, left_dev, left_dev_oe_n
  );
  modport ctl (
    output pixel_word_in, right_ctl, right_ctl_oe_n, left_ctl, left_ctl_oe_n,
    output line_strobe, dir_sel, dir_open, output_polarity, invert_low_dots,
    output invert_high_dots, chan_sel, chan_open, low_power_ctl, lpc_open,
    input right_chain_pulse, left_chain_pulse
  );
endinterface : column_link_if
`default_nettype wire

//--- rtl/column_loader_pkg.sv
// Types shared by both ends of the column loader link
`default_nettype none
`include "column_loader_regs.svh"
package column_loader_pkg;
  typedef logic [`CL_DOT_W-1:0] dot_type;
  typedef logic [`CL_COLS-1:0][`CL_DOT_W-1:0] row_type;
  typedef enum logic [1:0] {
    CTL_IDLE = 2'b00,
    CTL_STREAM = 2'b01,
    CTL_STROBE = 2'b11
  } ctl_state_type;
endpackage : column_loader_pkg
`default_nettype wire

//--- rtl/column_loader_regs.svh
// Constants of the column loader link and its controller registers
`ifndef COLUMN_LOADER_REGS_SVH
`define COLUMN_LOADER_REGS_SVH
`define CL_DOTS 6
`define CL_DOT_W 6
`define CL_WORD_W 36
`define CL_COLS 480
`define CL_CLK_FULL 7'd80
`define CL_CLK_PART 7'd70
`define CL_HALT_FULL 7'd82
`define CL_HALT_PART 7'd72
`define CL_GAP_FIRST 10'd210
`define CL_GAP_LEN 10'd60
`define CL_LAST_COL 10'd479
`define CL_STB_HIGH 7'd2
`define CL_STB_END 7'd4
`define CL_CTRL_OFS 8'h00
`define CL_CMD_OFS 8'h04
`define CL_STAT_OFS 8'h08
`define CL_CTRL_RST 32'h0000_0020
`define CL_B_DIR 0
`define CL_B_POL 1
`define CL_B_INVLO 2
`define CL_B_INVHI 3
`define CL_B_FULL 4
`define CL_B_LPC 5
`define CL_B_DIR_OPEN 8
`define CL_B_FULL_OPEN 9
`define CL_B_LPC_OPEN 10
`define CL_B_GO 0
`define CL_B_BUSY 0
`define CL_LINES_LSB 16
`endif

//--- rtl/timing_ctl_end.sv
// Panel timing controller end: APB registers, line sequencer
`timescale 1ns/1ps
`default_nettype none
`include "column_loader_regs.svh"
module timing_ctl_end (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Pixel source, word given in the cycle o_pixel_req is high
  input wire logic [35:0] i_pixel_word,
  output logic o_pixel_req,
  // Link to the driver
  column_link_if.ctl link
);

  typedef struct packed {
    column_loader_pkg::ctl_state_type state;
    logic [6:0] cnt;
    logic [31:0] ctrl;
    logic [15:0] lines;
    logic [35:0] word;
    logic start;
    logic stb;
    logic [31:0] ctl_out;
  } ctl_regs_type;

  ctl_regs_type st_r;
  ctl_regs_type st_nxt;

  logic access;
  logic [6:0] n_clk;
  logic busy;
  logic dir_eff;

  assign access = i_psel && i_penable;
  assign busy = st_r.state != column_loader_pkg::CTL_IDLE;
  assign n_clk = st_r.ctl_out[`CL_B_FULL] ? `CL_CLK_FULL : `CL_CLK_PART;

  // Register reads, unmapped offsets read zero with an error
  always_comb begin
    o_pready = 1'b1;
    o_pslverr = 1'b0;
    o_prdata = 32'h0000_0000;
    case (i_paddr)
      `CL_CTRL_OFS: o_prdata = st_r.ctrl;
      `CL_CMD_OFS: o_prdata = 32'h0000_0000;
      `CL_STAT_OFS: begin
        o_prdata[`CL_B_BUSY] = busy;
        o_prdata[`CL_LINES_LSB +: 16] = st_r.lines;
      end
      default: o_pslverr = i_psel;
    endcase
  end

  assign o_pixel_req = (st_r.state == column_loader_pkg::CTL_STREAM);

  // Sequencer: start with word 0, stream the line, then one strobe
  always_comb begin
    st_nxt = st_r;
    st_nxt.start = 1'b0;
    if (access && i_pwrite && i_paddr == `CL_CTRL_OFS) begin
      st_nxt.ctrl = i_pwdata;
    end
    case (st_r.state)
      column_loader_pkg::CTL_IDLE: begin
        // Settings reach the pins only between lines
        st_nxt.ctl_out = st_r.ctrl;
        if (access && i_pwrite && i_paddr == `CL_CMD_OFS &&
            i_pwdata[`CL_B_GO]) begin
          st_nxt.state = column_loader_pkg::CTL_STREAM;
          st_nxt.cnt = 7'd0;
        end
      end
      column_loader_pkg::CTL_STREAM: begin
        st_nxt.word = i_pixel_word;
        st_nxt.start = (st_r.cnt == 7'd0); // One clock high
        st_nxt.cnt = st_r.cnt + 7'd1;
        if (st_r.cnt == n_clk - 7'd1) begin
          st_nxt.state = column_loader_pkg::CTL_STROBE;
          st_nxt.cnt = 7'd0;
        end
      end
      column_loader_pkg::CTL_STROBE: begin
        // Gap cycle first so the last word lands before the latch
        st_nxt.cnt = st_r.cnt + 7'd1;
        st_nxt.stb = (st_r.cnt >= 7'd1) && (st_r.cnt <= `CL_STB_HIGH);
        if (st_r.cnt == `CL_STB_END) begin
          st_nxt.state = column_loader_pkg::CTL_IDLE;
          st_nxt.lines = st_r.lines + 16'd1;
          st_nxt.cnt = 7'd0;
        end
      end
      default: st_nxt.state = column_loader_pkg::CTL_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r <= '0;
      st_r.ctrl <= `CL_CTRL_RST;
      st_r.ctl_out <= `CL_CTRL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Link drive; start goes out on the pin the direction selects
  assign link.pixel_word_in = st_r.word;
  assign link.right_ctl = st_r.start;
  assign link.left_ctl = st_r.start;
  // Open direction strap reads as right shift at the driver
  assign dir_eff = st_r.ctl_out[`CL_B_DIR] | st_r.ctl_out[`CL_B_DIR_OPEN];
  assign link.right_ctl_oe_n = !dir_eff;
  assign link.left_ctl_oe_n = dir_eff;
  assign link.line_strobe = st_r.stb;
  assign link.dir_sel = st_r.ctl_out[`CL_B_DIR];
  assign link.dir_open = st_r.ctl_out[`CL_B_DIR_OPEN];
  assign link.output_polarity = st_r.ctl_out[`CL_B_POL];
  assign link.invert_low_dots = st_r.ctl_out[`CL_B_INVLO];
  assign link.invert_high_dots = st_r.ctl_out[`CL_B_INVHI];
  assign link.chan_sel = st_r.ctl_out[`CL_B_FULL];
  assign link.chan_open = st_r.ctl_out[`CL_B_FULL_OPEN];
  assign link.low_power_ctl = st_r.ctl_out[`CL_B_LPC];
  assign link.lpc_open = st_r.ctl_out[`CL_B_LPC_OPEN];

endmodule : timing_ctl_end
`default_nettype wire

//--- verif/column_link_properties.sv
// Checker for the link between controller and column driver
`timescale 1ns/1ps
`default_nettype none
module column_link_properties (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Chain pins, both parties
  input wire logic right_ctl,
  input wire logic right_ctl_oe_n,
  input wire logic left_ctl,
  input wire logic left_ctl_oe_n,
  input wire logic right_dev,
  input wire logic right_dev_oe_n,
  input wire logic left_dev,
  input wire logic left_dev_oe_n,
  // Line control and straps
  input wire logic line_strobe,
  input wire logic output_polarity,
  input wire logic dir_sel,
  input wire logic dir_open,
  input wire logic chan_sel,
  input wire logic chan_open
);
  logic dir_eff, full, start_in, chain_out;
  // Open straps read as right shift and 420 outputs
  assign dir_eff = dir_sel | dir_open;
  assign full = chan_sel & !chan_open;
  // Start as the controller drives it on the input pin
  assign start_in = dir_eff ? (right_ctl & !right_ctl_oe_n)
                            : (left_ctl & !left_ctl_oe_n);
  assign chain_out = dir_eff ? (left_dev & !left_dev_oe_n)
                             : (right_dev & !right_dev_oe_n);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  property p_start_once; start_in |=> !start_in; endproperty
  property p_out_full;
    start_in && full |-> ##80 !chain_out ##1 chain_out;
  endproperty
  property p_out_part;
    start_in && !full |-> ##70 !chain_out ##1 chain_out;
  endproperty
  property p_out_pulse; chain_out |=> !chain_out; endproperty
  property p_dir_right; dir_eff |-> right_dev_oe_n && !left_dev_oe_n; endproperty
  property p_dir_left; !dir_eff |-> !right_dev_oe_n && left_dev_oe_n; endproperty
  property p_dir_open; dir_open |-> right_dev_oe_n; endproperty
  // Strobe is two cycles wide by the controller's choice
  property p_strobe;
    $rose(line_strobe) |-> line_strobe ##1 line_strobe ##1 !line_strobe;
  endproperty
  property p_pol; $rose(line_strobe) |-> $stable(output_polarity); endproperty
  a_start_once: assert property (p_start_once) else $error("start too long");
  a_out_full: assert property (p_out_full) else $error("chain out 480");
  a_out_part: assert property (p_out_part) else $error("chain out 420");
  a_out_pulse: assert property (p_out_pulse) else $error("chain pulse");
  a_dir_right: assert property (p_dir_right) else $error("right dir");
  a_dir_left: assert property (p_dir_left) else $error("left dir");
  a_dir_open: assert property (p_dir_open) else $error("open dir");
  a_strobe: assert property (p_strobe) else $error("strobe width");
  a_pol: assert property (p_pol) else $error("polarity moved");
  c_full: cover property (start_in && full);
  c_part: cover property (start_in && !full);
  c_left: cover property (chain_out && !dir_eff);
  c_strobe: cover property ($rose(line_strobe));
endmodule : column_link_properties
`default_nettype wire

//--- verif/lcd_source_column_loader_bench.sv
// Bench joining controller and column driver, checking the driver outputs
`timescale 1ns/1ps
`default_nettype none
module lcd_source_column_loader_bench;
  logic i_core_clk = 0, i_rst = 1, psel = 0, pen = 0, pwr = 0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, preq, loading, odd_up, low_pw;
  logic [35:0] pix = 36'h0;
  logic [35:0] words [0:79];
  logic [31:0] ct [0:7];
  logic [2879:0] cols;
  logic [479:0] used;
  int idx = 0, bad_count = 0, num_checks = 0;
  column_link_if link();
  timing_ctl_end i_timing_ctl_end (.i_core_clk, .i_rst, .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_pixel_word(pix), .o_pixel_req(preq), .link(link.ctl));
  column_driver_end i_column_driver_end (.i_core_clk, .i_rst,
    .link(link.dev), .o_column_outputs(cols), .o_column_used(used),
    .o_odd_upper_group(odd_up), .o_low_power(low_pw), .o_loading(loading));
  column_link_properties i_column_link_properties (.i_core_clk, .i_rst,
    .right_ctl(link.right_ctl), .right_ctl_oe_n(link.right_ctl_oe_n),
    .left_ctl(link.left_ctl), .left_ctl_oe_n(link.left_ctl_oe_n),
    .right_dev(link.right_dev), .right_dev_oe_n(link.right_dev_oe_n),
    .left_dev(link.left_dev), .left_dev_oe_n(link.left_dev_oe_n),
    .line_strobe(link.line_strobe), .output_polarity(link.output_polarity),
    .dir_sel(link.dir_sel), .dir_open(link.dir_open),
    .chan_sel(link.chan_sel), .chan_open(link.chan_open));
  always #12.5 i_core_clk = ~i_core_clk;
  // Next word is ready before the cycle that asks for it
  always @(posedge i_core_clk) begin
    if (preq) begin
      idx <= idx + 1;
      pix <= words[(idx + 1) % 80];
    end
  end
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // One APB transfer; request held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge i_core_clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_core_clk);
    pen <= 1'b1;
    do @(posedge i_core_clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  // Load one line with control word c and compare the column stage
  task automatic run_line(input logic [31:0] c, input int n);
    logic f, d;
    logic [479:0] m;
    int k, j, b;
    f = c[4] & !c[9];
    d = c[0] | c[8];
    for (k = 0; k < 80; k++) words[k] = 36'({$urandom, $urandom});
    apb(1'b1, 8'h00, c);
    idx <= 0;
    pix <= words[0];
    apb(1'b1, 8'h04, 32'h0000_0001);
    k = 0;
    do begin
      apb(1'b0, 8'h08, 32'h0);
      k++;
    end while (q[0] !== 1'b0 && k < 100);
    chk("busy_clear", 0, q[0]);
    repeat (6) @(posedge i_core_clk);
    chk("lines", n, {16'h0, q[31:16]});
    m = '1;
    if (!f) m[269:210] = '0;
    chk("used_ok", 1, used === m);
    chk("odd_upper", !c[1], odd_up);
    chk("low_power", !(c[5] | c[10]), low_pw);
    chk("loading", 0, loading);
    for (k = 0; k < (f ? 80 : 70); k++) begin
      for (j = 0; j < 6; j++) begin
        b = 6 * k + j;
        if (!f && b >= 210) b += 60;
        if (!d) b = 479 - b;
        chk("column", words[k][6*j +: 6] ^ {6{j < 3 ? c[2] : c[3]}},
            cols[6*b +: 6]);
      end
    end
    $display("line %0d ctrl %h done", n, c);
  endtask : run_line
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict
  // Watchdog well beyond eight lines of about 100 cycles
  initial begin
    repeat (20000) @(posedge i_core_clk);
    bad_count++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'he370));
    ct[0] = 32'h0000_0700;
    ct[1] = 32'h0000_003f;
    // Left shift, 480 columns, low dots inverted, low power
    ct[2] = 32'h0000_0014;
    for (int i = 3; i < 8; i++) ct[i] = $urandom & 32'h0000_073f;
    repeat (20) @(posedge i_core_clk);
    i_rst <= 1'b0;
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl_reset", 32'h0000_0020, q);
    apb(1'b0, 8'h3c, 32'h0);
    chk("unmapped_err", 1, err);
    chk("unmapped_data", 0, q);
    $display("register tests done");
    for (int i = 0; i < 8; i++) run_line(ct[i], i + 1);
    print_verdict();
  end
endmodule : lcd_source_column_loader_bench
`default_nettype wire
